// [rtl/lv_qualifier.sv]
`timescale 1ns/1ps
// Qualifies the supply-low pin over a run of clock cycles
module lv_qualifier import rstc_pkg::*; #(
	parameter int unsigned QUALIFY_CYCLES = LV_QUALIFY_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic supply_low_pin,
	input wire logic hold_off,
	output logic lv_fire_q
);
	localparam int CW = $clog2(QUALIFY_CYCLES + 1);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic s1;
		logic s2;
		logic [CW-1:0] cnt;
		logic fire;
	} lvq_t;

	lvq_t q; // Registered state
	lvq_t d; // Next state

	// Counter must be able to count a run
	if (QUALIFY_CYCLES < 2) begin : g_bad_cycles
		$error("lv_qualifier: QUALIFY_CYCLES below 2");
	end

	// Count while the synchronised supply-low level stays high
	always_comb begin
		d = q;
		d.s1 = supply_low_pin;
		d.s2 = q.s1;
		d.fire = 1'b0;
		if (!q.s2 || hold_off) begin
			d.cnt = '0;
		end else if (q.cnt == CW'(QUALIFY_CYCLES - 1)) begin
			d.fire = 1'b1;
			d.cnt = '0;
		end else begin
			d.cnt = q.cnt + 1'b1;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign lv_fire_q = q.fire;

	// ****************************************
	// Checks
	// ****************************************
	AST_LV_TERMINAL: assert property (@(posedge pclk) disable iff (!presetn)
		q.fire |-> $past(q.cnt) == CW'(QUALIFY_CYCLES - 1))
		else $error("Low-voltage fire without full count");
	AST_LV_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
		!q.s2 |=> q.cnt == '0 && !q.fire)
		else $error("Low-voltage counter kept running");
endmodule

// [rtl/reset_ctrl.sv]
`timescale 1ns/1ps
// Reset source merger, watchdog and reset-cause flags
module reset_ctrl import rstc_pkg::*; #(
	parameter int unsigned LV_CYCLES = LV_QUALIFY_CYCLES,
	parameter int unsigned SOFT_CYCLES = SOFT_RESET_CYCLES,
	parameter int unsigned PULSE_CYCLES = RESET_PULSE_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire apb_req_t apb_in,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire cpu_event_t cpu_in,
	input wire logic slow_clk_pin,
	input wire logic supply_low_pin,
	output reset_out_t reset_out
);
	// ****************************************
	// Parameter checks
	// ****************************************
	if (SOFT_CYCLES < 1 || SOFT_CYCLES > 256) begin : g_bad_soft
		$error("reset_ctrl: SOFT_CYCLES out of 1..256");
	end
	if (PULSE_CYCLES < 1 || PULSE_CYCLES > 256) begin : g_bad_pulse
		$error("reset_ctrl: PULSE_CYCLES out of 1..256");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		phase_t phase;
		cause_t cause;
		logic [7:0] wdt_ctrl;
		logic [7:0] flash1;
		logic lv_flag;
		logic soft_flag;
		logic to;
		logic pd_flag;
		logic [17:0] wdt_cnt;
		logic [7:0] dly;
		logic l1;
		logic l2;
		logic l3;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic sys_reset;
		logic core_clear;
	} st_t;

	// Power-on state: reset pulse starts at release
	localparam st_t ST_INIT = '{
		phase: PH_RESET,
		cause: CAUSE_POWER_ON,
		wdt_ctrl: WDT_CTRL_RESET,
		flash1: FLASH1_RESET,
		lv_flag: 1'b0,
		soft_flag: 1'b0,
		to: 1'b0,
		pd_flag: 1'b0,
		wdt_cnt: 18'h0_0000,
		dly: 8'(PULSE_CYCLES - 1),
		l1: 1'b0,
		l2: 1'b0,
		l3: 1'b0,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: 32'h0000_0000,
		sys_reset: 1'b1,
		core_clear: 1'b0
	};

	st_t q; // Registered state
	st_t d; // Next state
	logic lv_fire; // Qualified supply-low pulse
	logic acc; // APB access phase
	logic wr; // Write takes effect
	logic tick; // Slow clock rising edge
	logic wdt_to; // Watchdog overflow
	logic live; // Sources accepted
	logic ev_wdt_act; // Timeout while running
	logic ev_wdt_slp; // Timeout while asleep
	logic ev_lv; // Low-voltage reset
	logic ev_key; // Flash control reset key
	logic ev_field; // Enable field delay expired
	logic ev_bad_wr; // Bad enable value written
	logic start_full; // Full reset begins
	logic [7:0] rd; // Read data byte

	// ****************************************
	// Functions
	// ****************************************
	// Enable field holds one of the two run codes
	function automatic logic en_ok(input logic [4:0] f);
		en_ok = (f == WDT_EN_A) || (f == WDT_EN_B);
	endfunction

	// Terminal count for each period code
	function automatic logic [17:0] wdt_mask(input logic [2:0] sel);
		unique case (sel)
			3'h0: wdt_mask = 18'h0_00FF;
			3'h1: wdt_mask = 18'h0_03FF;
			3'h2: wdt_mask = 18'h0_0FFF;
			3'h3: wdt_mask = 18'h0_3FFF;
			3'h4: wdt_mask = 18'h0_7FFF;
			3'h5: wdt_mask = 18'h0_FFFF;
			3'h6: wdt_mask = 18'h1_FFFF;
			3'h7: wdt_mask = 18'h3_FFFF;
		endcase
	endfunction

	// Word address decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a[7:2] == ofs[7:2]);
	endfunction

	// ****************************************
	// Supply-low qualifier
	// ****************************************
	lv_qualifier #(
		.QUALIFY_CYCLES(LV_CYCLES)
	) lv_qualifier_i (
		.pclk(pclk),
		.presetn(presetn),
		.supply_low_pin(supply_low_pin),
		.hold_off(cpu_in.low_power || q.sys_reset),
		.lv_fire_q(lv_fire)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		// Events
		acc = apb_in.psel && apb_in.penable;
		wr = acc && q.pready && apb_in.pwrite && !q.pslverr;
		tick = q.l2 && !q.l3;
		wdt_to = tick && (q.wdt_cnt >= wdt_mask(q.wdt_ctrl[WS_MSB:0]));
		live = (q.phase != PH_RESET);
		ev_wdt_act = live && wdt_to && !cpu_in.low_power;
		ev_wdt_slp = live && wdt_to && cpu_in.low_power;
		ev_lv = live && lv_fire;
		ev_key = live && wr && hit(apb_in.paddr, OFS_FLASH1)
			&& (apb_in.pwdata[7:0] == FLASH_RESET_KEY);
		ev_bad_wr = wr && hit(apb_in.paddr, OFS_WDT_CTRL)
			&& !en_ok(apb_in.pwdata[7:WE_LSB]);
		ev_field = (q.phase == PH_SOFT) && (q.dly == 8'h00);
		start_full = ev_lv || ev_field || ev_key || ev_wdt_act;
		d = q;
		d.core_clear = 1'b0;

		// Slow clock synchroniser and edge detect
		d.l1 = slow_clk_pin;
		d.l2 = q.l1;
		d.l3 = q.l2;

		// Read mux
		rd = 8'h00;
		if (hit(apb_in.paddr, OFS_WDT_CTRL)) begin
			rd = q.wdt_ctrl;
		end else if (hit(apb_in.paddr, OFS_CAUSE)) begin
			rd[LV_FLAG_BIT] = q.lv_flag;
			rd[SOFT_FLAG_BIT] = q.soft_flag;
		end else if (hit(apb_in.paddr, OFS_STATUS)) begin
			rd[TIMEOUT_BIT] = q.to;
			rd[PDOWN_BIT] = q.pd_flag;
		end else if (hit(apb_in.paddr, OFS_FLASH1)) begin
			rd = q.flash1;
		end

		// APB slave: one wait cycle, then ready
		d.pready = acc && !q.pready;
		d.pslverr = 1'b0;
		if (acc && !q.pready) begin
			d.pslverr = !(hit(apb_in.paddr, OFS_WDT_CTRL) || hit(apb_in.paddr, OFS_CAUSE)
				|| hit(apb_in.paddr, OFS_STATUS) || hit(apb_in.paddr, OFS_FLASH1));
			if (!apb_in.pwrite) begin
				d.prdata = {24'h00_0000, rd};
			end
		end

		// Register writes
		if (wr) begin
			if (hit(apb_in.paddr, OFS_WDT_CTRL)) begin
				d.wdt_ctrl = apb_in.pwdata[7:0];
			end
			if (hit(apb_in.paddr, OFS_CAUSE)) begin
				// Writing zero clears; writing one keeps
				d.lv_flag = q.lv_flag && apb_in.pwdata[LV_FLAG_BIT];
				d.soft_flag = q.soft_flag && apb_in.pwdata[SOFT_FLAG_BIT];
			end
			if (hit(apb_in.paddr, OFS_FLASH1)) begin
				d.flash1 = apb_in.pwdata[7:0];
			end
		end

		// Watchdog counter
		if (cpu_in.clear_wdt || cpu_in.halt || ev_bad_wr || wdt_to) begin
			d.wdt_cnt = 18'h0_0000;
		end else if (tick) begin
			d.wdt_cnt = q.wdt_cnt + 18'h0_0001;
		end

		// Core instruction effects on status flags
		if (live && cpu_in.halt) begin
			d.pd_flag = 1'b1;
			d.to = 1'b0;
		end else if (live && cpu_in.clear_wdt) begin
			d.pd_flag = 1'b0;
		end

		// Sleep timeout: wake, clear PC and SP only
		if (ev_wdt_slp) begin
			d.to = 1'b1;
			d.pd_flag = 1'b1;
			d.core_clear = 1'b1;
			d.cause = CAUSE_WDT_SLEEP;
		end

		// Sequencer
		unique case (q.phase)
			PH_RUN: begin
				// Any bad enable code, written or upset, arms the delay
				if (!en_ok(q.wdt_ctrl[7:WE_LSB])) begin
					d.phase = PH_SOFT;
					d.dly = 8'(SOFT_CYCLES - 1);
				end
			end
			PH_SOFT: begin
				if (q.dly != 8'h00) begin
					d.dly = q.dly - 8'h01;
				end
			end
			PH_RESET: begin
				if (q.dly == 8'h00) begin
					d.phase = PH_RUN;
					d.sys_reset = 1'b0;
				end else begin
					d.dly = q.dly - 8'h01;
				end
			end
			default: begin
				d.phase = PH_RESET;
				d.dly = 8'(PULSE_CYCLES - 1);
				d.sys_reset = 1'b1;
			end
		endcase

		// Full reset entry, low voltage first
		if (start_full) begin
			d.phase = PH_RESET;
			d.dly = 8'(PULSE_CYCLES - 1);
			d.sys_reset = 1'b1;
			d.wdt_ctrl = WDT_CTRL_RESET;
			d.flash1 = FLASH1_RESET;
			d.wdt_cnt = 18'h0_0000;
			d.core_clear = 1'b0;
			if (ev_lv) begin
				d.cause = CAUSE_LOW_VOLTAGE;
				d.lv_flag = 1'b1;
				d.to = q.to;
				d.pd_flag = q.pd_flag;
			end else if (ev_field) begin
				d.cause = CAUSE_WDT_FIELD;
				d.soft_flag = 1'b1;
			end else if (ev_key) begin
				d.cause = CAUSE_FLASH_KEY;
			end else begin
				d.cause = CAUSE_WDT_ACTIVE;
				d.to = 1'b1;
				d.pd_flag = q.pd_flag;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// Power-on clears both status flags and starts the pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= ST_INIT;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign reset_out = '{full: q.sys_reset, core_clear: q.core_clear, cause: q.cause};

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_WDT_ACTIVE_FULL: assert property (
		ev_wdt_act && !ev_lv && !ev_field && !ev_key
		|=> q.sys_reset && q.to && q.cause == CAUSE_WDT_ACTIVE)
		else $error("Active timeout did not give full reset");
	AST_WDT_SLEEP_CORE: assert property (
		ev_wdt_slp && !start_full |=> q.core_clear && q.to && q.pd_flag && !q.sys_reset)
		else $error("Sleep timeout handled wrongly");
	AST_WDT_CLEAR: assert property (
		(cpu_in.clear_wdt || cpu_in.halt) |=> q.wdt_cnt == 18'h0_0000)
		else $error("Watchdog counter not cleared");
	AST_SOFT_FLAG_CAUSE: assert property (
		$rose(q.soft_flag) |-> q.sys_reset && q.cause == CAUSE_WDT_FIELD
			&& $past(q.phase) == PH_SOFT)
		else $error("Soft reset flag set without field reset");
	AST_LV_FLAG: assert property (
		ev_lv |=> q.lv_flag && q.sys_reset && q.cause == CAUSE_LOW_VOLTAGE)
		else $error("Low-voltage reset not taken");
	AST_LV_SLEEP_OFF: assert property (
		cpu_in.low_power |=> !lv_fire)
		else $error("Low-voltage detection active in sleep");
	AST_FLASH_KEY_RESET: assert property (
		ev_key && !ev_lv && !ev_field |=> q.sys_reset && q.cause == CAUSE_FLASH_KEY)
		else $error("Flash control key did not reset");
	AST_CAUSE_RSVD: assert property (
		q.pready && !apb_in.pwrite && hit(apb_in.paddr, OFS_CAUSE)
		|-> q.prdata[31:3] == 29'h0 && !q.prdata[1])
		else $error("Reserved cause bits read nonzero");
	AST_PULSE_LEN: assert property (
		$rose(q.sys_reset) |-> q.sys_reset [*4] ##1 !q.sys_reset || start_full)
		else $error("Reset pulse length wrong");
	AST_HALT_PD: assert property (
		cpu_in.halt && live && !start_full |=> q.pd_flag && !q.to)
		else $error("Halt did not set power-down flag");

	COV_WDT_ACTIVE: cover property (ev_wdt_act ##1 q.sys_reset);
	COV_WDT_SLEEP: cover property (ev_wdt_slp ##1 q.core_clear);
	COV_LV: cover property (ev_lv ##1 q.lv_flag);
	COV_FIELD: cover property (ev_bad_wr ##[1:300] ev_field);
endmodule

// [rtl/rstc_pkg.sv]
// What this block does
// - Active-mode watchdog timeout: full reset, timeout flag
// - Sleep watchdog timeout clears only PC and SP
// - Clear, halt or bad enable write clear watchdog
// - Watchdog period spans 2^8 to 2^18 slow ticks
// - Power-on reset starts program at address zero
// - Power-on sets port data and direction ones
// - Qualified supply-low gives full reset, sets flag
// - Short supply-low dips are ignored entirely
// - Low-voltage detection off in sleep or idle
// - Low-voltage flag bit 2, software clears only
// - Cause register bits 7..3 and 1 read zero
// - Writing 55h to flash control resets device
// - Timeout and power-down flags follow reset cause
// - Power-on disables interrupts, restarts watchdog, timers off
// - Bad enable field resets after delay, sets flag
// - Period select codes pick the eight dividers
// - Soft reset flag bit 0, software clears only
// - Halt sets power-down; clear or power-up clears
package rstc_pkg;
	// Clock rate and times
	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned LV_QUALIFY_NS = 120000;
	localparam int unsigned LV_QUALIFY_CYCLES = (LV_QUALIFY_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned SOFT_RESET_CYCLES = 16;
	localparam int unsigned RESET_PULSE_CYCLES = 4;
	// Register offsets
	localparam logic [7:0] OFS_WDT_CTRL = 8'h00;
	localparam logic [7:0] OFS_CAUSE = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_FLASH1 = 8'h0C;
	// Values after reset and keys
	localparam logic [7:0] WDT_CTRL_RESET = 8'h53;
	localparam logic [7:0] FLASH1_RESET = 8'h00;
	localparam logic [4:0] WDT_EN_A = 5'h0A;
	localparam logic [4:0] WDT_EN_B = 5'h15;
	localparam logic [7:0] FLASH_RESET_KEY = 8'h55;
	// Field positions
	localparam int LV_FLAG_BIT = 2;
	localparam int SOFT_FLAG_BIT = 0;
	localparam int TIMEOUT_BIT = 0;
	localparam int PDOWN_BIT = 1;
	localparam int WS_MSB = 2;
	localparam int WE_LSB = 3;
	// Reset cause codes
	typedef enum logic [2:0] {
		CAUSE_POWER_ON = 3'h0,
		CAUSE_LOW_VOLTAGE = 3'h1,
		CAUSE_WDT_ACTIVE = 3'h2,
		CAUSE_WDT_SLEEP = 3'h3,
		CAUSE_WDT_FIELD = 3'h4,
		CAUSE_FLASH_KEY = 3'h5
	} cause_t;
	// Sequencer states
	typedef enum logic [2:0] {
		PH_RUN = 3'b001,
		PH_SOFT = 3'b010,
		PH_RESET = 3'b100
	} phase_t;
	// APB request from the master
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	// Core events, same clock
	typedef struct packed {
		logic clear_wdt;
		logic halt;
		logic low_power;
	} cpu_event_t;
	// Reset outputs to the core
	typedef struct packed {
		logic full;
		logic core_clear;
		cause_t cause;
	} reset_out_t;
endpackage

// [test/test_reset_ctrl.sv]
`timescale 1ns/1ps
// Compare one value with its expectation and count the outcome
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module test_reset_ctrl import rstc_pkg::*; ;
	// ****************************************
	// Signals and settings
	// ****************************************
	localparam int LVC = 8; // Short supply-low qualification
	localparam int PLC = 4; // Full reset pulse length
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	apb_req_t apb_r = '0;
	cpu_event_t cpu_r = '0;
	logic slow_clk_pin = 1'b0;
	logic supply_low_pin = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	reset_out_t reset_out;
	logic [2:0] lc = 3'h0; // Divider for the slow clock
	typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
	note_t note_q[$]; // Expected APB answers, oldest first
	note_t nt;
	int n_fail = 0;
	int total_checks = 0;
	logic [7:0] fd;
	int k;
	// ****************************************
	// Clocks and design
	// ****************************************
	initial forever #25 pclk = ~pclk;
	// Slow clock at one eighth of pclk, phase free against the watchdog
	always @(posedge pclk) begin
		lc <= lc + 3'h1;
		slow_clk_pin <= lc[2];
	end
	reset_ctrl #(.LV_CYCLES(LVC), .SOFT_CYCLES(16), .PULSE_CYCLES(PLC)) reset_ctrl_i (
		.pclk(pclk), .presetn(presetn), .apb_in(apb_r), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_in(cpu_r), .slow_clk_pin(slow_clk_pin),
		.supply_low_pin(supply_low_pin), .reset_out(reset_out));
	// ****************************************
	// Monitor and tasks
	// ****************************************
	// Each answer takes the oldest note off the queue
	always @(posedge pclk) begin
		if (pready === 1'b1) begin
			if (note_q.size() == 0) begin
				n_fail++;
				$display("Error apb note expected 1 seen 0");
			end else begin
				nt = note_q.pop_front();
				`CHK("pslverr", nt.e, pslverr)
				`CHK("prdata", nt.d, prdata & nt.m)
			end
		end
	end
	// Verdict and end of run
	task automatic stop_test();
		$display("Checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// A wait ran out of its bound
	task automatic hung();
		n_fail++;
		$display("Error wait expected done seen timeout");
		stop_test();
	endtask
	// One APB transfer; setup, access, hold until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] ed, input logic [31:0] m, input logic ee);
		int j;
		note_q.push_back('{ed, m, ee});
		@(posedge pclk);
		apb_r <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_r.penable <= 1'b1;
		j = 0;
		do begin
			@(posedge pclk);
			j++;
		end while (pready !== 1'b1 && j < 50);
		if (j >= 50) hung();
		apb_r.psel <= 1'b0;
		apb_r.penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m);
		apb(1'b0, a, 32'h0000_0000, ed, m, 1'b0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0);
	endtask
	// One-cycle core event: 0 clear-watchdog, 1 halt
	task automatic ev(input int s);
		@(posedge pclk);
		if (s == 0) cpu_r.clear_wdt <= 1'b1;
		else cpu_r.halt <= 1'b1;
		@(posedge pclk);
		cpu_r.clear_wdt <= 1'b0;
		cpu_r.halt <= 1'b0;
	endtask
	// No reset of either kind for n cycles
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge pclk);
			`CHK("no reset", 2'b00, {reset_out.full, reset_out.core_clear})
		end
	endtask
	// Full reset within lo..hi edges, with its cause and pulse length
	task automatic see_full(input int mx, input int lo, input int hi, input cause_t c);
		int h;
		k = 0;
		while (reset_out.full !== 1'b1 && k < mx) begin
			@(posedge pclk);
			k++;
		end
		if (k >= mx) hung();
		`CHK("reset delay in range", 1'b1, (k >= lo && k <= hi))
		`CHK("cause", c, reset_out.cause)
		h = 0;
		while (reset_out.full === 1'b1 && h < 20) begin
			@(posedge pclk);
			h++;
		end
		`CHK("full length", PLC, h)
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h6c2fa774));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Let the release edge pass so the pulse is counted from its start
		@(posedge pclk);
		see_full(2, 0, 0, CAUSE_POWER_ON);
		rd(OFS_WDT_CTRL, 32'h0000_0053, 32'h0000_00ff);
		rd(OFS_CAUSE, 32'h0000_0000, 32'hffff_fffb);
		rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0003);
		rd(OFS_FLASH1, 32'h0000_0000, 32'h0000_00ff);
		apb(1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 1'b1);
		apb(1'b1, 8'h10, 32'h0000_00ff, 32'h0000_0000, 32'h0000_0000, 1'b1);
		wr(OFS_WDT_CTRL, 32'h0000_00a8);
		rd(OFS_WDT_CTRL, 32'h0000_00a8, 32'h0000_00ff);
		// Shortest period; a clear in between must hold it off
		wr(OFS_WDT_CTRL, 32'h0000_0050);
		ev(0);
		quiet(1500);
		ev(0);
		see_full(2200, 2030, 2075, CAUSE_WDT_ACTIVE);
		rd(OFS_STATUS, 32'h0000_0001, 32'h0000_0003);
		rd(OFS_WDT_CTRL, 32'h0000_0053, 32'h0000_00ff);
		// Sleep timeout at code 1 clears only PC and SP
		wr(OFS_WDT_CTRL, 32'h0000_0051);
		cpu_r.low_power <= 1'b1;
		ev(1);
		k = 0;
		while (reset_out.core_clear !== 1'b1 && k < 8400) begin
			@(posedge pclk);
			k++;
			`CHK("full in sleep", 1'b0, reset_out.full)
		end
		if (k >= 8400) hung();
		`CHK("sleep delay in range", 1'b1, (k >= 8170 && k <= 8230))
		`CHK("sleep cause", CAUSE_WDT_SLEEP, reset_out.cause)
		@(posedge pclk);
		`CHK("core_clear length", 1'b0, reset_out.core_clear)
		rd(OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
		supply_low_pin <= 1'b1;
		quiet(20);
		supply_low_pin <= 1'b0;
		cpu_r.low_power <= 1'b0;
		// Let the synchroniser empty so the first dip starts from a low level
		quiet(4);
		// Dips shorter than the qualification time
		for (int i = 0; i < 2; i++) begin
			supply_low_pin <= 1'b1;
			repeat (i == 0 ? $urandom_range(1, LVC - 2) : LVC - 1) @(posedge pclk);
			supply_low_pin <= 1'b0;
			quiet(20);
		end
		supply_low_pin <= 1'b1;
		see_full(40, LVC, LVC + 8, CAUSE_LOW_VOLTAGE);
		supply_low_pin <= 1'b0;
		rd(OFS_STATUS, 32'h0000_0003, 32'h0000_0003);
		rd(OFS_CAUSE, 32'h0000_0004, 32'h0000_00ff);
		ev(0);
		rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0002);
		// Bad enable value resets after the delay
		wr(OFS_WDT_CTRL, 32'h0000_0000);
		see_full(40, 15, 20, CAUSE_WDT_FIELD);
		rd(OFS_WDT_CTRL, 32'h0000_0053, 32'h0000_00ff);
		rd(OFS_CAUSE, 32'h0000_0005, 32'h0000_00ff);
		// Flash key: other values stored, the key resets
		fd = 8'($urandom_range(0, 255));
		if (fd == FLASH_RESET_KEY) fd = 8'h54;
		wr(OFS_FLASH1, {24'h00_0000, fd});
		rd(OFS_FLASH1, {24'h00_0000, fd}, 32'h0000_00ff);
		quiet(4);
		wr(OFS_FLASH1, 32'h0000_0055);
		see_full(10, 0, 3, CAUSE_FLASH_KEY);
		rd(OFS_FLASH1, 32'h0000_0000, 32'h0000_00ff);
		// Writing ones keeps the flags, writing zero clears them
		wr(OFS_CAUSE, 32'hffff_ffff);
		rd(OFS_CAUSE, 32'h0000_0005, 32'hffff_ffff);
		wr(OFS_CAUSE, 32'h0000_0000);
		rd(OFS_CAUSE, 32'h0000_0000, 32'hffff_ffff);
		stop_test();
	end
endmodule
